// *** hdl/psmb_target.sv ***
// Purpose: two-wire bus target with management port and record store
// Assumes: clk well above 8x scl rate; no clock stretching
// Notes: record store reloads its image on reset (no retention)
`timescale 1ns/10ps
// Function
// - controller address from straps, B0h..B6h
// - controller also answers general call 00h
// - write guard high blocks all memory writes
// - record store address from straps, A0h..A6h
// - byte/sequential reads, byte/page writes supported
// - controller follows SMBus 2.0 framing
// - record image uses format version 1.0
// - header marks internal-use area absent
// - product area padded to 8-byte boundary
// - asset tag stored as zero length
// - multi-record holds only types 00, 01
// - flags mark hot swap, autoswitch, PFC
module psmb_target
   import psmb_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic scl_i,
   input wire logic sda_i,
   output logic sda_o,
   output logic sda_oe,
   input wire logic addr_strap_bit0,
   input wire logic addr_strap_bit1,
   input wire logic wp_i,
   output logic mgmt_rx_valid,
   output logic [7:0] mgmt_rx_byte,
   output logic mgmt_rx_cmd,
   output logic mgmt_rx_gcall,
   input wire logic [7:0] mgmt_tx_byte,
   output logic mgmt_tx_take
);
   import psmb_pkg::*;

   typedef struct packed {
      psmb_state_t st;
      logic scl_p;
      logic sda_p;
      logic [7:0] sh;
      logic [3:0] cnt;
      logic rd;
      logic is_rec;
      logic gcall;
      logic first;
      logic mack;
      logic [7:0] ptr;
      logic sda_oe;
      logic sda_lvl;
      logic rx_valid;
      logic [7:0] rx_byte;
      logic rx_cmd;
      logic tx_take;
      logic mem_we;
      logic [7:0] mem_wa;
      logic [7:0] mem_wd;
   } psmb_regs_t;

   psmb_regs_t s_q;
   psmb_regs_t s_d;
   logic [4:0] pins_s;
   logic scl_s;
   logic sda_s;
   logic [1:0] strap_s;
   logic wp_s;
   logic rise;
   logic fall;
   logic start;
   logic stop;
   logic [6:0] mgmt_addr;
   logic [6:0] rec_addr;
   logic hit_mgmt;
   logic hit_rec;
   logic hit_gcall;
   logic [7:0] mem [0:PSMB_MEM_DEPTH-1];

   // ------------------------------------------------------------------
   // pin synchronisers
   // ------------------------------------------------------------------
   psmb_sync #(.W(5)) u_sync (
      .clk(clk),
      .rst_n(rst_n),
      .pin_i({wp_i, addr_strap_bit1, addr_strap_bit0, sda_i, scl_i}),
      .sync_o(pins_s)
   );

   assign scl_s = pins_s[0];
   assign sda_s = pins_s[1];
   assign strap_s = pins_s[3:2];
   assign wp_s = pins_s[4];

   // bus events from synced levels and their previous sample
   assign rise = scl_s & ~s_q.scl_p;
   assign fall = ~scl_s & s_q.scl_p;
   assign start = scl_s & s_q.scl_p & s_q.sda_p & ~sda_s;
   assign stop = scl_s & s_q.scl_p & ~s_q.sda_p & sda_s;

   // address decode on the completed address byte
   assign mgmt_addr = psmb_addr(PSMB_MGMT_BASE, strap_s);
   assign rec_addr = psmb_addr(PSMB_REC_BASE, strap_s);
   assign hit_mgmt = (s_q.sh[7:1] == mgmt_addr);
   assign hit_rec = (s_q.sh[7:1] == rec_addr);
   // general call is write-only
   assign hit_gcall = (s_q.sh[7:1] == PSMB_GCALL_ADDR) & ~s_q.sh[0];

   // ------------------------------------------------------------------
   // bus state machine
   // ------------------------------------------------------------------
   always_comb begin
      s_d = s_q;
      s_d.scl_p = scl_s;
      s_d.sda_p = sda_s;
      s_d.rx_valid = 1'b0;
      s_d.tx_take = 1'b0;
      s_d.mem_we = 1'b0;
      if (stop) begin
         s_d.st = ST_IDLE;
         s_d.sda_oe = 1'b0;
      end else if (start) begin
         // repeated start keeps the record pointer
         s_d.st = ST_ADDR;
         s_d.cnt = PSMB_CNT_ZERO;
         s_d.sda_oe = 1'b0;
      end else begin
         unique case (s_q.st)
            ST_IDLE: begin
               s_d.sda_oe = 1'b0;
            end
            ST_ADDR: begin
               if (rise) begin
                  s_d.sh = {s_q.sh[6:0], sda_s};
                  s_d.cnt = s_q.cnt + 4'h1;
               end else if (fall && s_q.cnt == PSMB_BYTE_BITS) begin
                  // ack only our own addresses
                  if (hit_mgmt || hit_rec || hit_gcall) begin
                     s_d.st = ST_ACK;
                     s_d.sda_oe = 1'b1;
                     s_d.rd = s_q.sh[0];
                     s_d.is_rec = hit_rec;
                     s_d.gcall = hit_gcall;
                     s_d.first = 1'b1;
                  end else begin
                     s_d.st = ST_IDLE;
                  end
               end
            end
            ST_ACK: begin
               // ack bit held for the whole high phase
               if (fall) begin
                  s_d.cnt = PSMB_CNT_ZERO;
                  if (s_q.rd) begin
                     s_d.st = ST_TX;
                     s_d.sh = s_q.is_rec ? mem[s_q.ptr] : mgmt_tx_byte;
                     s_d.sda_oe = s_q.is_rec ? ~mem[s_q.ptr][7]
                                             : ~mgmt_tx_byte[7];
                     s_d.tx_take = ~s_q.is_rec;
                  end else begin
                     s_d.st = ST_RX;
                     s_d.sda_oe = 1'b0;
                  end
               end
            end
            ST_RX: begin
               if (rise) begin
                  s_d.sh = {s_q.sh[6:0], sda_s};
                  s_d.cnt = s_q.cnt + 4'h1;
               end else if (fall && s_q.cnt == PSMB_BYTE_BITS) begin
                  s_d.st = ST_ACK;
                  s_d.sda_oe = 1'b1;
                  s_d.first = 1'b0;
                  if (s_q.is_rec) begin
                     if (s_q.first) begin
                        s_d.ptr = s_q.sh; // word address
                     end else begin
                        // page write wraps in 8 bytes
                        s_d.ptr = {s_q.ptr[7:3], s_q.ptr[2:0] + 3'h1};
                        s_d.mem_we = ~wp_s;
                        s_d.mem_wa = s_q.ptr;
                        s_d.mem_wd = s_q.sh;
                     end
                  end else begin
                     // command byte always passes; payload is guarded
                     s_d.rx_valid = s_q.first | ~wp_s;
                     s_d.rx_byte = s_q.sh;
                     s_d.rx_cmd = s_q.first;
                  end
               end
            end
            ST_TX: begin
               if (rise) begin
                  s_d.cnt = s_q.cnt + 4'h1;
               end else if (fall) begin
                  if (s_q.cnt == PSMB_BYTE_BITS) begin
                     s_d.st = ST_RACK;
                     s_d.sda_oe = 1'b0;
                     if (s_q.is_rec) begin
                        s_d.ptr = s_q.ptr + 8'h01; // sequential
                     end
                  end else begin
                     s_d.sh = {s_q.sh[6:0], 1'b0};
                     s_d.sda_oe = ~s_q.sh[6];
                  end
               end
            end
            ST_RACK: begin
               // controller ack keeps the read going, nack ends it
               if (rise) begin
                  s_d.mack = ~sda_s;
               end else if (fall) begin
                  if (s_q.mack) begin
                     s_d.st = ST_TX;
                     s_d.cnt = PSMB_CNT_ZERO;
                     s_d.sh = s_q.is_rec ? mem[s_q.ptr] : mgmt_tx_byte;
                     s_d.sda_oe = s_q.is_rec ? ~mem[s_q.ptr][7]
                                             : ~mgmt_tx_byte[7];
                     s_d.tx_take = ~s_q.is_rec;
                  end else begin
                     s_d.st = ST_IDLE;
                  end
               end
            end
            default: begin
               s_d.st = ST_IDLE;
               s_d.sda_oe = 1'b0;
            end
         endcase
      end
   end

   // state register; bus is released during reset
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         s_q <= '0;
         s_q.st <= ST_IDLE;
         s_q.scl_p <= 1'b1;
         s_q.sda_p <= 1'b1;
         s_q.ptr <= PSMB_PTR_RST;
         s_q.sh <= PSMB_BYTE_ZERO;
      end else begin
         s_q <= s_d;
      end
   end

   // ------------------------------------------------------------------
   // record store; image reloaded on reset
   // ------------------------------------------------------------------
   // a flop array keeps the reload simple at the cost of area
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         for (int i = 0; i < PSMB_MEM_DEPTH; i++) begin
            mem[i] <= psmb_img(i);
         end
      end else if (s_q.mem_we) begin
         mem[s_q.mem_wa] <= s_q.mem_wd;
      end
   end

   // outputs straight from the state register
   assign sda_o = s_q.sda_lvl;
   assign sda_oe = s_q.sda_oe;
   assign mgmt_rx_valid = s_q.rx_valid;
   assign mgmt_rx_byte = s_q.rx_byte;
   assign mgmt_rx_cmd = s_q.rx_cmd;
   assign mgmt_rx_gcall = s_q.gcall;
   assign mgmt_tx_take = s_q.tx_take;

   // ------------------------------------------------------------------
   // assertions
   // ------------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   sequence addr_done;
      s_q.st == ST_ADDR && !start && !stop && fall
         && s_q.cnt == PSMB_BYTE_BITS;
   endsequence

   sequence acked;
      s_q.st == ST_ACK && s_q.sda_oe;
   endsequence

   mgmt_addr_a: assert property (
      addr_done and (s_q.sh[7:1] == mgmt_addr) |=> acked and !s_q.is_rec)
      else $error("controller address not acknowledged");

   gen_call_a: assert property (
      addr_done and (s_q.sh == PSMB_BYTE_ZERO) |=> acked and s_q.gcall)
      else $error("general call not acknowledged");

   wp_block_a: assert property (
      s_q.mem_we |-> !$past(wp_s))
      else $error("record written while guarded");

   rec_addr_a: assert property (
      addr_done and (s_q.sh[7:1] == rec_addr) |=> acked and s_q.is_rec)
      else $error("record store address not acknowledged");

   foreign_a: assert property (
      addr_done and !hit_mgmt and !hit_rec and !hit_gcall
         |=> s_q.st == ST_IDLE && !s_q.sda_oe)
      else $error("foreign address acknowledged");

   seq_read_a: assert property (
      s_q.st == ST_TX && s_q.is_rec && fall && !start && !stop
         && s_q.cnt == PSMB_BYTE_BITS
         |=> s_q.st == ST_RACK && s_q.ptr == $past(s_q.ptr) + 8'h01)
      else $error("read pointer did not advance");

   ack_hold_a: assert property (
      acked and !fall and !start and !stop |=> s_q.sda_oe)
      else $error("ack released before clock fall");

   img_hdr_a: assert property (
      $rose(rst_n) |-> mem[PSMB_HDR_INT_OFS] == PSMB_AREA_ABSENT
         && mem[PSMB_HDR_VER_OFS] == PSMB_FMT_VER
         && mem[PSMB_PS_FLAGS_OFS] == PSMB_PS_FLAGS)
      else $error("record header image wrong after reset");

endmodule : psmb_target

// *** hdl/psmb_pkg.sv ***
// Purpose: shared constants, types and record image for the bus target
// Assumes: 7-bit two-wire addressing, 256-byte record store
// Notes: image holds header, product and multi-record areas only
package psmb_pkg;

   // ------------------------------------------------------------------
   // bus addressing
   // ------------------------------------------------------------------
   localparam logic [6:0] PSMB_MGMT_BASE = 7'h58;
   localparam logic [6:0] PSMB_REC_BASE = 7'h50;
   localparam logic [6:0] PSMB_GCALL_ADDR = 7'h00;
   localparam logic [3:0] PSMB_BYTE_BITS = 4'h8;
   localparam logic [3:0] PSMB_CNT_ZERO = 4'h0;
   localparam logic [7:0] PSMB_PTR_RST = 8'h00;
   localparam logic [7:0] PSMB_BYTE_ZERO = 8'h00;
   localparam logic [7:0] PSMB_ERASED = 8'hff;

   // ------------------------------------------------------------------
   // record store layout
   // ------------------------------------------------------------------
   localparam int PSMB_MEM_DEPTH = 256;
   localparam int PSMB_IMG_LEN = 71;
   localparam logic [7:0] PSMB_HDR_VER_OFS = 8'h00;
   localparam logic [7:0] PSMB_HDR_INT_OFS = 8'h01;
   localparam logic [7:0] PSMB_HDR_MR_OFS = 8'h05;
   localparam logic [7:0] PSMB_FMT_VER = 8'h01;
   localparam logic [7:0] PSMB_AREA_ABSENT = 8'h00;
   localparam logic [7:0] PSMB_PS_FLAGS_OFS = 8'h2e;
   localparam logic [7:0] PSMB_PS_FLAGS = 8'h1e;

   // one-hot bus states
   typedef enum logic [5:0] {
      ST_IDLE = 6'b000001,
      ST_ADDR = 6'b000010,
      ST_ACK  = 6'b000100,
      ST_RX   = 6'b001000,
      ST_TX   = 6'b010000,
      ST_RACK = 6'b100000
   } psmb_state_t;

   // header v1, no internal area, product at 8, multi-record at 24
   // product area padded to 16 bytes, asset tag empty (c0)
   // multi-record: supply info (type 00) then dc output (type 01, last)
   localparam logic [7:0] PSMB_IMG [0:PSMB_IMG_LEN-1] = '{
      8'h01, 8'h00, 8'h00, 8'h00, 8'h01, 8'h03, 8'h00, 8'hfb,
      8'h01, 8'h02, 8'h00, 8'hc0, 8'hc0, 8'hc0, 8'hc0, 8'hc0,
      8'hc0, 8'hc0, 8'hc1, 8'h00, 8'h00, 8'h00, 8'h00, 8'hfc,
      8'h00, 8'h02, 8'h18, 8'h64, 8'h82,
      8'h96, 8'h00, 8'hff, 8'hff, 8'h00, 8'h00, 8'h28, 8'h23,
      8'h20, 8'h67, 8'h00, 8'h00, 8'h00, 8'h00, 8'h2f, 8'h3f,
      8'h14, 8'h1e, 8'h96, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
      8'h01, 8'h82, 8'h0d, 8'h67, 8'h09,
      8'h01, 8'hb0, 8'h04, 8'h74, 8'h04, 8'hec, 8'h04, 8'h78,
      8'h00, 8'h00, 8'h00, 8'hd4, 8'h30
   };

   // power-up content of one record byte
   function automatic logic [7:0] psmb_img(input int idx);
      psmb_img = (idx < PSMB_IMG_LEN) ? PSMB_IMG[idx] : PSMB_ERASED;
   endfunction : psmb_img

   // strapped 7-bit address from a base
   function automatic logic [6:0] psmb_addr(input logic [6:0] base,
                                            input logic [1:0] strap);
      psmb_addr = base | {5'h00, strap};
   endfunction : psmb_addr

endpackage : psmb_pkg

// *** hdl/psmb_sync.sv ***
// Purpose: two-stage synchroniser for pin inputs
// Assumes: inputs are asynchronous to clk
// Notes: first stage feeds only the second
`timescale 1ns/10ps
module psmb_sync #(
   parameter int W = 5
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [W-1:0] pin_i,
   output logic [W-1:0] sync_o
);

   logic [W-1:0] meta_q;
   logic [W-1:0] sync_q;

   // ------------------------------------------------------------------
   // double flop; resets to released-bus level
   // ------------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         meta_q <= '1;
         sync_q <= '1;
      end else begin
         meta_q <= pin_i;
         sync_q <= meta_q;
      end
   end

   assign sync_o = sync_q;

endmodule : psmb_sync

// *** test/psmb_host.sv ***
// Purpose: system-side bus controller model driving scl and sda
// Assumes: sda wire has a pull-up; target only pulls low
// Notes: phases in clk cycles; extra slows every phase
`timescale 1ns/10ps
module psmb_host (
   input wire logic clk,
   input wire logic sda_w,
   output logic scl,
   output logic sda
);
   int unsigned extra;

   // idle bus: scl stands high between frames, sda released
   initial begin
      scl = 1'b1;
      sda = 1'b1;
      extra = 0;
   end

   // ---------------------------------------------
   // bit timing
   // ---------------------------------------------
   task automatic hold(input int n);
      repeat (n + extra) @(negedge clk);
   endtask : hold

   // one bit; low and high phases each 4 clk at least
   task automatic xfer(input logic v, output logic s);
      sda = v;
      hold(2);
      scl = 1'b1;
      hold(3);
      s = sda_w; // late in high phase, after target settles
      hold(1);
      scl = 1'b0;
      hold(2);
   endtask : xfer

   // ---------------------------------------------
   // framing
   // ---------------------------------------------
   task automatic bus_start;
      sda = 1'b0;
      hold(4);
      scl = 1'b0;
      hold(2);
   endtask : bus_start

   task automatic bus_stop;
      sda = 1'b0;
      hold(2);
      scl = 1'b1;
      hold(4);
      sda = 1'b1;
      hold(4);
   endtask : bus_stop

   // msb first, ack on the 9th clock
   task automatic put_byte(input logic [7:0] b, output logic ack);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         xfer(b[i], s);
      end
      xfer(1'b1, s);
      ack = ~s;
   endtask : put_byte

   // nack on the last byte ends a sequential read
   task automatic get_byte(input logic nack, output logic [7:0] b);
      logic s;
      for (int i = 0; i < 8; i++) begin
         xfer(1'b1, s);
         b = {b[6:0], s};
      end
      xfer(nack, s);
   endtask : get_byte
endmodule : psmb_host

// *** test/tb_top.sv ***
// Purpose: self-checking bench for the two-wire management target
// Assumes: psmb_host plays the system bus controller
// Notes: writes tracked in exp_mem; image checked field by field
`timescale 1ns/10ps
module tb_top;
   import psmb_pkg::*;
   logic clk, rst_n, scl_i, sda_i, sda_o, sda_oe, host_sda, wp_i;
   logic addr_strap_bit0, addr_strap_bit1, mgmt_rx_valid, mgmt_rx_cmd;
   logic mgmt_rx_gcall, mgmt_tx_take;
   logic [7:0] mgmt_rx_byte, mgmt_tx_byte, rec8, mgmt8;
   logic [9:0] rxq[$];
   logic [7:0] img[$];
   logic [7:0] exp_mem[int];
   int err_count, checks, takes;

   psmb_target psmb_target_inst (.clk, .rst_n, .scl_i, .sda_i, .sda_o,
      .sda_oe, .addr_strap_bit0, .addr_strap_bit1, .wp_i, .mgmt_rx_valid,
      .mgmt_rx_byte, .mgmt_rx_cmd, .mgmt_rx_gcall, .mgmt_tx_byte,
      .mgmt_tx_take);
   psmb_host psmb_host_inst (.clk, .sda_w(sda_i), .scl(scl_i),
      .sda(host_sda));

   // open-drain wire: low if either side pulls, pull-up otherwise
   assign sda_i = host_sda & ~(sda_oe & ~sda_o);

   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end

   // controller-port monitor; falling edge sees each settled pulse once
   always @(negedge clk) begin
      if (mgmt_rx_valid === 1'b1) rxq.push_back({mgmt_rx_cmd,
         mgmt_rx_gcall, mgmt_rx_byte});
      if (mgmt_tx_take === 1'b1) takes++;
   end

   // ---------------------------------------------
   // compare and bus tasks
   // ---------------------------------------------
   task automatic chk8(input string w, input logic [7:0] e, g);
      checks++;
      if (g !== e) begin
         err_count++;
         $display("unexpected %s: expected %h, seen %h", w, e, g);
      end
   endtask : chk8

   task automatic chk1(input string w, input logic e, g);
      checks++;
      if (g !== e) begin
         err_count++;
         $display("unexpected %s: expected %b, seen %b", w, e, g);
      end
   endtask : chk1

   task automatic chk_rx(input int i, input logic c, g,
                         input logic [7:0] b);
      chk1("rx cmd flag", c, rxq[i][9]);
      chk1("rx gcall flag", g, rxq[i][8]);
      chk8("rx byte", b, rxq[i][7:0]);
   endtask : chk_rx

   // addresses given in 8-bit form, direction bit replaced
   task automatic addr8(input logic [7:0] a, input logic rd,
                        output logic ack);
      psmb_host_inst.bus_start;
      psmb_host_inst.put_byte({a[7:1], rd}, ack);
   endtask : addr8

   task automatic set_straps(input int s);
      {addr_strap_bit1, addr_strap_bit0} = 2'(s);
      rec8 = 8'ha0 + 8'(2 * s);
      mgmt8 = 8'hb0 + 8'(2 * s);
      repeat (6) @(negedge clk); // straps pass a synchroniser
   endtask : set_straps

   task automatic rec_write(input logic [7:0] p, d);
      logic a;
      addr8(rec8, 1'b0, a);
      psmb_host_inst.put_byte(p, a);
      psmb_host_inst.put_byte(d, a);
      chk1("record data ack", 1'b1, a);
      psmb_host_inst.bus_stop;
      if (wp_i == 1'b0) exp_mem[p] = d;
   endtask : rec_write

   // pointer write, stop, then current-address sequential read
   task automatic rec_read(input logic [7:0] p, input int n);
      logic a;
      logic [7:0] d;
      addr8(rec8, 1'b0, a);
      psmb_host_inst.put_byte(p, a);
      psmb_host_inst.bus_stop;
      addr8(rec8, 1'b1, a);
      chk1("record read ack", 1'b1, a);
      for (int i = 0; i < n; i++) begin
         psmb_host_inst.get_byte(i == n - 1, d);
         img.push_back(d);
      end
      psmb_host_inst.bus_stop;
   endtask : rec_read

   task automatic close_out;
      $display("comparisons %0d, mismatches %0d", checks, err_count);
      if (err_count == 0 && checks > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : close_out

   // hang guard well above the longest sequence
   initial begin
      repeat (90000) @(posedge clk);
      err_count++;
      $display("unexpected timeout: expected end, seen hang");
      close_out;
   end

   // ---------------------------------------------
   // main sequence
   // ---------------------------------------------
   initial begin
      logic a;
      logic [7:0] d, p, cmd;
      int q, mr;
      void'($urandom(55440));
      rst_n = 1'b0;
      wp_i = 1'b0;
      mgmt_tx_byte = 8'h00;
      {addr_strap_bit1, addr_strap_bit0} = 2'b00;
      repeat (3) @(negedge clk); // reset held three cycles
      rst_n = 1'b1;
      repeat (4) @(negedge clk);
      // every strap setting, own and foreign addresses
      for (int s = 0; s < 4; s++) begin
         set_straps(s);
         addr8(rec8, 1'b0, a);
         psmb_host_inst.bus_stop;
         chk1("record addr ack", 1'b1, a);
         addr8(mgmt8, 1'b0, a);
         psmb_host_inst.bus_stop;
         chk1("mgmt addr ack", 1'b1, a);
         addr8(8'ha0 + 8'(2 * ((s + 1) % 4)), 1'b0, a);
         psmb_host_inst.bus_stop;
         chk1("foreign addr ack", 1'b0, a);
      end
      // general call write: command then payload
      set_straps(2);
      cmd = 8'($urandom);
      d = 8'($urandom);
      addr8(8'h00, 1'b0, a);
      chk1("gcall ack", 1'b1, a);
      psmb_host_inst.put_byte(cmd, a);
      psmb_host_inst.put_byte(d, a);
      psmb_host_inst.bus_stop;
      chk8("rx count", 8'h02, 8'(rxq.size()));
      chk_rx(0, 1'b1, 1'b1, cmd);
      chk_rx(1, 1'b0, 1'b1, d);
      // guarded write: payload refused, command still passes
      rxq.delete();
      wp_i = 1'b1;
      addr8(mgmt8, 1'b0, a);
      psmb_host_inst.put_byte(cmd, a);
      psmb_host_inst.put_byte(d, a);
      psmb_host_inst.bus_stop;
      chk8("rx count guarded", 8'h01, 8'(rxq.size()));
      chk_rx(0, 1'b1, 1'b0, cmd);
      // controller read; general call read refused
      mgmt_tx_byte = 8'($urandom);
      takes = 0;
      addr8(mgmt8, 1'b1, a);
      chk1("mgmt read ack", 1'b1, a);
      psmb_host_inst.get_byte(1'b1, d);
      psmb_host_inst.bus_stop;
      chk8("mgmt read byte", mgmt_tx_byte, d);
      chk8("tx take count", 8'h01, 8'(takes));
      addr8(8'h00, 1'b1, a);
      psmb_host_inst.bus_stop;
      chk1("gcall read ack", 1'b0, a);
      // record writes, guard alternating on each of four locations
      for (int i = 0; i < 8; i++) begin
         if (i % 2 == 0) p = 8'h60 + 8'($urandom_range(159, 0));
         wp_i = i[0]; // lowered before an intended write
         rec_write(p, 8'($urandom));
         img.delete();
         rec_read(p, 1);
         chk8("record byte", exp_mem[p], img[0]);
      end
      // mid-run reset: store reloads its image, written byte is lost
      rst_n = 1'b0;
      repeat (3) @(negedge clk);
      rst_n = 1'b1;
      repeat (4) @(negedge clk);
      img.delete();
      rec_read(p, 1);
      chk8("record after reset", PSMB_ERASED, img[0]);
      // image read with a slow controller
      wp_i = 1'b0;
      psmb_host_inst.extra = 2;
      img.delete();
      rec_read(8'h00, 56);
      psmb_host_inst.extra = 0;
      chk8("format version", 8'h01, img[0]);
      chk8("internal area", 8'h00, img[1]);
      chk8("next area start", 8'(img[4] + img[9]), img[5]);
      q = 11;
      repeat (5) q += 1 + img[q][5:0];
      chk8("asset tag", 8'hc0, img[q]);
      mr = 8 * img[5];
      chk8("first record type", 8'h00, img[mr]);
      q = mr + 5 + img[mr + 2];
      chk8("second record type", 8'h01, img[q]);
      chk1("list end", 1'b1, img[q + 1][7]);
      chk8("supply flags", 8'h1c, img[mr + 22] & 8'h1c);
      close_out;
   end
endmodule : tb_top
